// ---- hw/electronic_gear_scaler.sv ----
// electronic gear: reference units to encoder pulses with ratio check
`timescale 1ns/1ps
`include "gear_defs.svh"
module electronic_gear_scaler
  import gear_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  input  wire logic [30:0]        gear_numerator,
  input  wire logic [30:0]        gear_denominator,
  input  wire logic               resolution_compat_select,
  input  wire logic               ref_valid,
  input  wire logic signed [31:0] ref_delta,
  output logic                    ref_ready,
  output logic                    pulse_valid,
  output logic signed [63:0]      pulse_count,
  output logic                    param_error,
  output logic                    feedback_20bit,
  output logic                    config_ok
);

  // ********************************************************************
  // state
  // ********************************************************************
  gear_state_e        state_r;
  gear_state_e        state_nxt;
  gear_cfg_s          cfg_r;
  logic [30:0]        carry_r;
  logic               neg_r;
  logic               ready_r;
  logic               err_r;
  logic               ok_r;
  logic               fb20_r;
  pulse_s             out_r;

  // ********************************************************************
  // settings check
  // ********************************************************************
  function automatic logic in_set_range(input logic [30:0] v);
    in_set_range = (v >= `GEAR_SET_MIN) && (v <= `GEAR_SET_MAX);
  endfunction

  wire [63:0] num_w    = {33'h000000000, cfg_r.numerator};
  wire [63:0] den_w    = {33'h000000000, cfg_r.denominator};
  wire [63:0] hi_limit = cfg_r.compat_select ? `GEAR_RATIO_HI_20BIT  // R05
                                             : `GEAR_RATIO_HI_NATIVE; // R04
  // ratio >= 1/1000 and ratio <= limit, cross-multiplied so no fraction is needed
  wire        lo_ok    = (num_w * `GEAR_RATIO_LO_DEN) >= den_w; // R04 R05
  wire        hi_ok    = num_w <= (den_w * hi_limit); // R04 R05
  wire        sets_ok  = in_set_range(cfg_r.numerator) && in_set_range(cfg_r.denominator); // R02 R03
  wire        ratio_ok = sets_ok && lo_ok && hi_ok;

  // ********************************************************************
  // scaling datapath
  // ********************************************************************
  // product width covers the largest delta times the largest numerator, so the
  // top reference rate at any legal ratio cannot wrap
  wire signed [63:0] delta_w = {{32{ref_delta[31]}}, ref_delta};
  wire signed [63:0] prod_w  = delta_w * $signed(num_w); // R01 R07 R08
  wire signed [63:0] acc_w   = prod_w + $signed({33'h000000000, carry_r}); // R12
  wire        [63:0] mag_w   = acc_w[63] ? 64'(-acc_w) : 64'(acc_w);
  wire               take    = ref_valid && ready_r;

  logic              div_done;
  logic [63:0]       div_quo;
  logic [31:0]       div_rem;

  gear_divider u_div (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .start     (take),
    .dividend  (mag_w),
    .divisor   (cfg_r.denominator),
    .done      (div_done),
    .quotient  (div_quo),
    .remainder (div_rem)
  );

  // floor division keeps the carried remainder in 0..den-1 for both travel directions
  wire        rem_zero = (div_rem == 32'h00000000);
  wire [63:0] q_up     = div_quo + 64'h0000000000000001;
  wire signed [63:0] q_signed = !neg_r   ? $signed(div_quo)
                              : rem_zero ? $signed(64'(-div_quo))
                                         : $signed(64'(-q_up)); // R01
  wire [31:0] den32    = {1'b0, cfg_r.denominator};
  wire [31:0] r_neg    = den32 - div_rem;
  wire [30:0] carry_nxt = (!neg_r || rem_zero) ? div_rem[30:0] : r_neg[30:0]; // R12

  // ********************************************************************
  // sequencing
  // ********************************************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_LOAD:  state_nxt = ST_CHECK;
      ST_CHECK: state_nxt = ratio_ok ? ST_IDLE : ST_ALARM; // R06
      ST_IDLE:  state_nxt = take ? ST_DIV : ST_IDLE;
      ST_DIV:   state_nxt = div_done ? ST_IDLE : ST_DIV;
      ST_ALARM: state_nxt = ST_ALARM;
      default:  state_nxt = ST_LOAD;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_r <= ST_LOAD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // settings are sampled once after restart and then held; later changes on
  // the inputs are ignored until the next reset
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cfg_r.numerator     <= `GEAR_NUM_RESET; // R02
      cfg_r.denominator   <= `GEAR_DEN_RESET; // R03
      cfg_r.compat_select <= 1'b0;
    end else if (state_r == ST_LOAD) begin
      cfg_r.numerator     <= gear_numerator; // R02
      cfg_r.denominator   <= gear_denominator; // R03
      cfg_r.compat_select <= resolution_compat_select;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      err_r  <= 1'b0;
      ok_r   <= 1'b0;
      fb20_r <= 1'b0;
    end else if (state_r == ST_CHECK) begin
      err_r  <= !ratio_ok; // R06
      ok_r   <= ratio_ok;
      fb20_r <= cfg_r.compat_select; // R05
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= (state_nxt == ST_IDLE) && !take;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      neg_r   <= 1'b0;
      carry_r <= 31'h00000000;
    end else if (take) begin
      neg_r   <= acc_w[63];
    end else if (state_r == ST_DIV && div_done) begin
      carry_r <= carry_nxt; // R12
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      out_r.valid <= 1'b0;
      out_r.count <= 64'sh0000000000000000;
    end else begin
      out_r.valid <= (state_r == ST_DIV) && div_done;
      if ((state_r == ST_DIV) && div_done) begin
        out_r.count <= q_signed; // R01
      end
    end
  end

  // ********************************************************************
  // outputs
  // ********************************************************************
  assign ref_ready      = ready_r;
  assign pulse_valid    = out_r.valid;
  assign pulse_count    = out_r.count;
  assign param_error    = err_r;
  assign feedback_20bit = fb20_r;
  assign config_ok      = ok_r;

endmodule // electronic_gear_scaler

// ---- inc/gear_defs.svh ----
// constants of the electronic gear scaler
// ********************************************************************
// How it works
// (R01) each commanded travel in reference units becomes encoder pulses times numerator/denominator.
// (R02) the numerator spans 1 to 1,073,741,824, resets to 64 and is taken only at restart.
// (R03) the denominator spans 1 to 1,073,741,824, resets to 1 and is taken only at restart.
// (R04) with compatibility select 0 the ratio must lie within 0.001 to 64,000 inclusive.
// (R05) with compatibility select 1 feedback counts as 20 bits and the ratio must lie in 0.001 to 4,000.
// (R06) a ratio outside the permitted range raises the parameter setting alarm.
// (R07) at 115,343,500 units/s a 16,777,216-count encoder reaches 413 min^-1 at ratio 1, 6,600 at 16.
// (R08) a 4,194,304-count encoder gives 1,650 min^-1 at ratio 1 and 6,600 at 4; 1,048,576 gives 6,600.
// (R09) the host computes the rotary ratio as resolution over travel per load turn times m/n.
// (R10) if the host gears itself, the drive ratio should be set 1:1.
// (R11) for linear motors the ratio is travel per unit times encoder resolution over encoder pitch.
// (R12) the division remainder is carried into the next reference so the total never drifts.
// ********************************************************************
`ifndef GEAR_DEFS_SVH
`define GEAR_DEFS_SVH

`define GEAR_SET_MIN        31'h00000001
`define GEAR_SET_MAX        31'h40000000
`define GEAR_NUM_RESET      31'h00000040
`define GEAR_DEN_RESET      31'h00000001
`define GEAR_RATIO_LO_DEN   64'h00000000000003E8
`define GEAR_RATIO_HI_NATIVE 64'h000000000000FA00
`define GEAR_RATIO_HI_20BIT 64'h0000000000000FA0
`define GEAR_MAX_REF_RATE   32'h06E0008C
`define GEAR_SPEED_RPM_MAX  16'h19C8
`define GEAR_DIV_STEPS      7'h40

`endif

// ---- inc/gear_pkg.sv ----
// types of the electronic gear scaler
package gear_pkg;

  typedef enum logic [2:0] {
    ST_LOAD  = 3'b000,
    ST_CHECK = 3'b001,
    ST_IDLE  = 3'b010,
    ST_DIV   = 3'b011,
    ST_ALARM = 3'b100
  } gear_state_e;

  typedef struct packed {
    logic [30:0] numerator;
    logic [30:0] denominator;
    logic        compat_select;
  } gear_cfg_s;

  typedef struct packed {
    logic               valid;
    logic signed [63:0] count;
  } pulse_s;

endpackage

// ---- hw/gear_divider.sv ----
// restoring unsigned divider, one quotient bit per clock
`timescale 1ns/1ps
`include "gear_defs.svh"
module gear_divider
  import gear_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        start,
  input  wire logic [63:0] dividend,
  input  wire logic [30:0] divisor,
  output logic             done,
  output logic [63:0]      quotient,
  output logic [31:0]      remainder
);
  logic [6:0]  cnt_r;
  logic [31:0] rem_r;
  logic [63:0] quo_r;
  logic        done_r;
  wire  [31:0] shifted  = {rem_r[30:0], quo_r[63]};
  wire  [32:0] trial    = {1'b0, shifted} - {2'b00, divisor};
  wire         fits     = ~trial[32];

  // a long divide keeps the area small; 64 clocks per reference is ample at 25 MHz
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cnt_r  <= 7'h00;
      rem_r  <= 32'h00000000;
      quo_r  <= 64'h0000000000000000;
      done_r <= 1'b0;
    end else if (start) begin
      cnt_r  <= `GEAR_DIV_STEPS;
      rem_r  <= 32'h00000000;
      quo_r  <= dividend;
      done_r <= 1'b0;
    end else if (cnt_r != 7'h00) begin
      cnt_r  <= cnt_r - 7'h01;
      rem_r  <= fits ? trial[31:0] : shifted;
      quo_r  <= {quo_r[62:0], fits};
      done_r <= (cnt_r == 7'h01);
    end else begin
      done_r <= 1'b0;
    end
  end

  assign done      = done_r;
  assign quotient  = quo_r;
  assign remainder = rem_r;
endmodule // gear_divider

// ---- tb/electronic_gear_scaler_chk.sv ----
// port assertions for the gear scaler
`timescale 1ns/1ps
module electronic_gear_scaler_chk (
  input wire logic               clk_sys,
  input wire logic               nrst,
  input wire logic [30:0]        gear_numerator,
  input wire logic [30:0]        gear_denominator,
  input wire logic               resolution_compat_select,
  input wire logic               ref_valid,
  input wire logic signed [31:0] ref_delta,
  input wire logic               ref_ready,
  input wire logic               pulse_valid,
  input wire logic signed [63:0] pulse_count,
  input wire logic               param_error,
  input wire logic               feedback_20bit,
  input wire logic               config_ok
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  take_answer_a: assert property (ref_valid && ref_ready |-> ##66 pulse_valid)
    else $error("no pulse 66 cycles after take");
  busy_quiet_a: assert property (ref_valid && ref_ready |=> (!ref_ready && !pulse_valid)[*8])
    else $error("busy window broken");
  pulse_single_a: assert property (pulse_valid |=> !pulse_valid)
    else $error("pulse longer than one cycle");
  count_hold_a: assert property (!pulse_valid |-> $stable(pulse_count))
    else $error("count moved without pulse");
  alarm_sticky_a: assert property (param_error |=> param_error)
    else $error("alarm cleared without reset");
  alarm_block_a: assert property (param_error |-> !ref_ready && !config_ok && !pulse_valid)
    else $error("alarm not blocking");
  mode_copy_a: assert property (config_ok |-> feedback_20bit == resolution_compat_select)
    else $error("mode flag wrong");
  set_range_a: assert property (config_ok |-> gear_numerator inside {[1:31'h40000000]}
    && gear_denominator inside {[1:31'h40000000]}) else $error("setting out of range");
  ratio_range_a: assert property (config_ok |-> 64'(gear_numerator) * 1000 >=
    64'(gear_denominator) && 64'(gear_numerator) <= 64'(gear_denominator) *
    (resolution_compat_select ? 4000 : 64000)) else $error("ratio out of range");
endmodule // electronic_gear_scaler_chk
bind electronic_gear_scaler electronic_gear_scaler_chk electronic_gear_scaler_chk_inst (
  .clk_sys, .nrst, .gear_numerator, .gear_denominator, .resolution_compat_select,
  .ref_valid, .ref_delta, .ref_ready, .pulse_valid, .pulse_count, .param_error,
  .feedback_20bit, .config_ok);

// ---- tb/host_ref_model.sv ----
// host controller model offering position references
`timescale 1ns/1ps
module host_ref_model (
  input  wire logic          clk_sys,
  input  wire logic          ref_ready,
  output logic               ref_valid,
  output logic signed [31:0] ref_delta
);
  initial begin
    ref_valid = 1'b0;
    ref_delta = 32'h0;
  end
  // called at a falling edge; holds the offer until a rising edge with ready high
  task automatic send(input logic signed [31:0] d);
    int n;
    n = 0;
    ref_valid = 1'b1;
    ref_delta = d;
    while (ref_ready !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    @(negedge clk_sys);
    ref_valid = 1'b0;
    ref_delta = ~d; // released bus must not look like the last value
  endtask
endmodule // host_ref_model

// ---- tb/electronic_gear_scaler_tb.sv ----
// self-checking bench of the gear scaler
`timescale 1ns/1ps
module electronic_gear_scaler_tb;
  import gear_pkg::*;
  logic               clk_sys = 1'b0;
  logic               nrst = 1'b0;
  logic [30:0]        num = 31'h40;
  logic [30:0]        den = 31'h1;
  logic               sel = 1'b0;
  logic               ref_valid, ref_ready, pulse_valid, param_error, fb20, cfg_ok;
  logic signed [31:0] ref_delta;
  logic signed [63:0] pulse_count;
  longint             cum;
  int                 bad_count = 0;
  int                 checks_done = 0;
  gear_cfg_s          tab [10] = '{{31'h1, 31'h3E8, 1'b0}, {31'h1, 31'h3E9, 1'b0},
    {31'hFA00, 31'h1, 1'b0}, {31'hFA01, 31'h1, 1'b0}, {31'hFA0, 31'h1, 1'b1},
    {31'hFA1, 31'h1, 1'b1}, {31'h0, 31'h5, 1'b0}, {31'h5, 31'h0, 1'b0},
    {31'h40000000, 31'h40000000, 1'b1}, {31'h40000001, 31'h40000001, 1'b0}};
  logic [9:0]         err_exp = 10'h2EA;
  always #20 clk_sys = ~clk_sys;
  electronic_gear_scaler electronic_gear_scaler_inst (.clk_sys, .nrst, .gear_numerator(num),
    .gear_denominator(den), .resolution_compat_select(sel), .ref_valid, .ref_delta,
    .ref_ready, .pulse_valid, .pulse_count, .param_error, .feedback_20bit(fb20),
    .config_ok(cfg_ok));
  host_ref_model host_ref_model_inst (.clk_sys, .ref_ready, .ref_valid, .ref_delta);
  task automatic cmp1(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %0b seen %0b", nm, e, g);
    end
  endtask
  task automatic cmp64(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %0d seen %0d", nm, $signed(e), $signed(g));
    end
  endtask
  // floor of a*num/den, remainder kept non-negative
  function automatic longint fl(input longint a);
    longint p;
    p = a * longint'(num);
    return (p < 0 && p % longint'(den) != 0) ? p / longint'(den) - 1 : p / longint'(den);
  endfunction
  // motor speed in min^-1, rounded, for one second of travel at the held count
  function automatic longint rpm(input longint enc);
    return (longint'(pulse_count) * 64'sh3C + enc / 2) / enc;
  endfunction
  task automatic restart(input gear_cfg_s c);
    @(negedge clk_sys);
    nrst = 1'b0;
    {num, den, sel} = c;
    repeat (10) @(negedge clk_sys);
    nrst = 1'b1;
    cum = 0;
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic xfer(input logic signed [31:0] d);
    longint e;
    int i;
    e = fl(cum + d) - fl(cum);
    cum += d;
    host_ref_model_inst.send(d);
    for (i = 0; i < 80 && pulse_valid !== 1'b1; i++) @(negedge clk_sys);
    cmp1("pulse_valid", 1'b1, pulse_valid);
    cmp64("pulse_count", e, pulse_count);
  endtask
  task automatic t_default;
    restart({31'h40, 31'h1, 1'b0});
    cmp1("config_ok", 1'b1, cfg_ok);
    xfer(32'sh3);
    xfer(-32'sh1);
    xfer(32'sh7FFFFFFF);
  endtask
  task automatic t_carry;
    restart({31'h1, 31'h3, 1'b0});
    repeat (3) xfer(32'sh1);
    xfer(-32'sh2);
    xfer(-32'sh2);
  endtask
  // one reference of a full second at the top reference rate
  task automatic t_speed;
    restart({31'h1, 31'h1, 1'b0});
    xfer(32'sh06E0008C);
    cmp64("speed_24bit_r1", 64'h19D, rpm(64'sh1000000));
    cmp64("speed_22bit_r1", 64'h672, rpm(64'sh400000));
    cmp64("speed_20bit_r1", 64'h19C8, rpm(64'sh100000));
    restart({31'h4, 31'h1, 1'b0});
    xfer(32'sh06E0008C);
    cmp64("speed_22bit_r4", 64'h19C8, rpm(64'sh400000));
    restart({31'h10, 31'h1, 1'b0});
    xfer(32'sh06E0008C);
    cmp64("speed_24bit_r16", 64'h19C8, rpm(64'sh1000000));
  endtask
  task automatic t_limits;
    for (int k = 0; k < 10; k++) begin
      restart(tab[k]);
      cmp1("param_error", err_exp[k], param_error);
      cmp1("config_ok", !err_exp[k], cfg_ok);
      cmp1("ref_ready", !err_exp[k], ref_ready);
      if (!err_exp[k]) cmp1("feedback_20bit", sel, fb20);
      if (!err_exp[k]) xfer(32'sh3E8);
    end
  endtask
  task automatic final_report;
    if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk_sys);
    t_default();
    t_carry();
    t_speed();
    t_limits();
    final_report();
  end
  initial begin
    #(40 * 5000);
    bad_count++;
    final_report();
  end
endmodule // electronic_gear_scaler_tb
